// ### hw/pcs_pkg.sv
package pcs_pkg;
    // ****************************************************************
    // register offsets (byte addresses in configuration space)
    // ****************************************************************
    localparam logic [7:0] PCS_CMD_OFFSET = 8'h04;
    localparam logic [7:0] PCS_STS_OFFSET = 8'h06;
    localparam logic [7:0] PCS_DWORD_OFFSET = 8'h04;

    // ****************************************************************
    // command field positions
    // ****************************************************************
    localparam int PCS_CMD_INT_DIS = 10;
    localparam int PCS_CMD_SERR_EN = 8;
    localparam int PCS_CMD_PERR_EN = 6;
    localparam int PCS_CMD_MWI_EN = 4;
    localparam int PCS_CMD_MST_EN = 2;
    localparam int PCS_CMD_MEM_EN = 1;
    localparam logic [15:0] PCS_CMD_RW_MASK = 16'h0556;
    localparam logic [15:0] PCS_CMD_RESET = 16'h0000;

    // ****************************************************************
    // status field positions and fixed values
    // ****************************************************************
    localparam int PCS_STS_PARITY = 15;
    localparam int PCS_STS_SYS_ERR = 14;
    localparam int PCS_STS_MST_ABORT = 13;
    localparam int PCS_STS_TABORT_RX = 12;
    localparam int PCS_STS_TABORT_TX = 11;
    localparam int PCS_STS_DATA_PAR = 8;
    localparam int PCS_STS_INT = 3;
    localparam logic [15:0] PCS_STS_FIXED = 16'h0210;
    localparam logic [15:0] PCS_STS_RESET = 16'h0000;
endpackage

// ### hw/pcs_regs.sv
// Summary of operation
// - command bits 15 to 11 read zero, writes ignored
// - command bit 10 masks the interrupt line, resets to 0
// - command bit 9 reads zero; no fast back-to-back mastering
// - command bit 8 enables the system error driver, resets to 0
// - command bit 7 reserved, reads zero, writes ignored
// - command bit 6 enables parity error drive, resets to 0
// - command bit 5 reads zero; no palette snooping
// - command bit 4 allows write-and-invalidate, else plain writes
// - command bit 3 reads zero; special cycles never claimed
// - command bit 2 gates all mastering, resets to 0
// - command bit 1 gates memory claims; host sets it first
// - command bit 0 reads zero; io cycles never claimed
// - status bit 15 sticks on ev_addr_par or ev_data_par until cleared
// - status bits 13, 12, 11 record the abort events
// - status bits 10 to 9 read fixed 01b
// - status bit 3 shows pending interrupt; line needs mask clear
module pcs_regs
    import pcs_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    // configuration dword access at offset 04h
    input wire logic cfg_sel,
    input wire logic cfg_wr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    // events from the bus engine, same clock
    input wire logic ev_addr_par,
    input wire logic ev_data_par,
    input wire logic ev_data_par_master,
    input wire logic ev_master_abort,
    input wire logic ev_target_abort_rx,
    input wire logic ev_target_abort_tx,
    input wire logic ev_serr_asserted,
    input wire logic irq_pending,
    // gating towards the bus engine
    output logic memory_space_en,
    output logic initiator_en,
    output logic write_invalidate_en,
    output logic parity_report_en,
    output logic system_error_drive_en,
    output logic io_space_en,
    output logic palette_snoop_en,
    output logic back_to_back_en,
    output logic special_cycle_en,
    output logic intx_assert
);
    // ****************************************************************
    // command register
    // ****************************************************************
    logic [15:0] cmd_r;
    logic [15:0] cmd_nxt;
    logic [15:0] wmask;

    always_comb begin
        wmask = {{8{cfg_be[1]}}, {8{cfg_be[0]}}} & PCS_CMD_RW_MASK;
        cmd_nxt = cmd_r;
        if (cfg_sel && cfg_wr) begin
            // only writable bits change
            cmd_nxt = (cmd_r & ~wmask) | (cfg_wdata[15:0] & wmask);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_r <= PCS_CMD_RESET;
        end else begin
            cmd_r <= cmd_nxt;
        end
    end

    // ****************************************************************
    // status register
    // ****************************************************************
    logic par_r, sys_r, mab_r, tar_r, tas_r, dpar_r, int_r;
    logic par_nxt, sys_nxt, mab_nxt, tar_nxt, tas_nxt, dpar_nxt;
    logic [15:0] clr;

    // set wins over a write-one clear in the same cycle
    always_comb begin
        clr = (cfg_sel && cfg_wr) ?
            (cfg_wdata[31:16] & {{8{cfg_be[3]}}, {8{cfg_be[2]}}}) : 16'h0000;
        par_nxt = (ev_addr_par | ev_data_par)
            | (par_r & ~clr[PCS_STS_PARITY]);
        sys_nxt = (ev_serr_asserted & cmd_r[PCS_CMD_SERR_EN])
            | (sys_r & ~clr[PCS_STS_SYS_ERR]);
        mab_nxt = ev_master_abort
            | (mab_r & ~clr[PCS_STS_MST_ABORT]);
        tar_nxt = ev_target_abort_rx
            | (tar_r & ~clr[PCS_STS_TABORT_RX]);
        tas_nxt = ev_target_abort_tx
            | (tas_r & ~clr[PCS_STS_TABORT_TX]);
        dpar_nxt = (ev_data_par_master & cmd_r[PCS_CMD_PERR_EN])
            | (dpar_r & ~clr[PCS_STS_DATA_PAR]);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            par_r <= 1'b0;
            sys_r <= 1'b0;
            mab_r <= 1'b0;
            tar_r <= 1'b0;
            tas_r <= 1'b0;
            dpar_r <= 1'b0;
            int_r <= 1'b0;
        end else begin
            par_r <= par_nxt;
            sys_r <= sys_nxt;
            mab_r <= mab_nxt;
            tar_r <= tar_nxt;
            tas_r <= tas_nxt;
            dpar_r <= dpar_nxt;
            int_r <= irq_pending;
        end
    end

    // ****************************************************************
    // read data and gating outputs
    // ****************************************************************
    logic [15:0] sts;
    logic [31:0] rdata_nxt;
    logic intx_nxt;

    always_comb begin
        sts = PCS_STS_FIXED;
        sts[PCS_STS_PARITY] = par_r;
        sts[PCS_STS_SYS_ERR] = sys_r;
        sts[PCS_STS_MST_ABORT] = mab_r;
        sts[PCS_STS_TABORT_RX] = tar_r;
        sts[PCS_STS_TABORT_TX] = tas_r;
        sts[PCS_STS_DATA_PAR] = dpar_r;
        sts[PCS_STS_INT] = int_r;
        rdata_nxt = {sts, cmd_nxt & PCS_CMD_RW_MASK};
        intx_nxt = irq_pending & ~cmd_nxt[PCS_CMD_INT_DIS];
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_rdata <= 32'h0000_0000;
            memory_space_en <= 1'b0;
            initiator_en <= 1'b0;
            write_invalidate_en <= 1'b0;
            parity_report_en <= 1'b0;
            system_error_drive_en <= 1'b0;
            io_space_en <= 1'b0;
            palette_snoop_en <= 1'b0;
            back_to_back_en <= 1'b0;
            special_cycle_en <= 1'b0;
            intx_assert <= 1'b0;
        end else begin
            cfg_rdata <= rdata_nxt;
            memory_space_en <= cmd_nxt[PCS_CMD_MEM_EN];
            initiator_en <= cmd_nxt[PCS_CMD_MST_EN];
            write_invalidate_en <= cmd_nxt[PCS_CMD_MWI_EN];
            parity_report_en <= cmd_nxt[PCS_CMD_PERR_EN];
            system_error_drive_en <= cmd_nxt[PCS_CMD_SERR_EN];
            io_space_en <= 1'b0;
            palette_snoop_en <= 1'b0;
            back_to_back_en <= 1'b0;
            special_cycle_en <= 1'b0;
            intx_assert <= intx_nxt;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    property p_cmd_ro_zero;
        @(posedge clk) disable iff (!arst_n)
        (cfg_rdata[15:11] == 5'h00) && !cfg_rdata[9] && !cfg_rdata[7]
        && !cfg_rdata[5] && !cfg_rdata[3] && !cfg_rdata[0];
    endproperty
    a_cmd_ro_zero: assert property (p_cmd_ro_zero)
        else $error("read-only command bits not zero");

    property p_intx_mask;
        @(posedge clk) disable iff (!arst_n)
        intx_assert |-> (int_r && !cmd_r[PCS_CMD_INT_DIS]);
    endproperty
    a_intx_mask: assert property (p_intx_mask)
        else $error("interrupt line asserted while masked");

    property p_no_b2b;
        @(posedge clk) disable iff (!arst_n)
        !back_to_back_en && !special_cycle_en && !io_space_en;
    endproperty
    a_no_b2b: assert property (p_no_b2b)
        else $error("unsupported feature enabled");

    property p_serr_follow;
        @(posedge clk) disable iff (!arst_n)
        system_error_drive_en == cmd_r[PCS_CMD_SERR_EN];
    endproperty
    a_serr_follow: assert property (p_serr_follow)
        else $error("system error enable mismatch");

    property p_mst_follow;
        @(posedge clk) disable iff (!arst_n)
        (cfg_sel && cfg_wr && cfg_be[0]) |=>
        initiator_en == $past(cfg_wdata[PCS_CMD_MST_EN]);
    endproperty
    a_mst_follow: assert property (p_mst_follow)
        else $error("initiator enable did not follow write");

    property p_mem_read;
        @(posedge clk) disable iff (!arst_n)
        cfg_rdata[PCS_CMD_MEM_EN] == memory_space_en;
    endproperty
    a_mem_read: assert property (p_mem_read)
        else $error("memory enable readback mismatch");

    property p_par_sticky;
        @(posedge clk) disable iff (!arst_n)
        (ev_addr_par || ev_data_par || (par_r && !clr[PCS_STS_PARITY]))
        |=> par_r;
    endproperty
    a_par_sticky: assert property (p_par_sticky)
        else $error("parity flag lost");

    property p_mab_set;
        @(posedge clk) disable iff (!arst_n)
        ev_master_abort |=> ##1 cfg_rdata[16 + PCS_STS_MST_ABORT];
    endproperty
    a_mab_set: assert property (p_mab_set)
        else $error("master abort not recorded");

    property p_speed;
        @(posedge clk) disable iff (!arst_n)
        1'b1 |=> cfg_rdata[26:25] == 2'b01;
    endproperty
    a_speed: assert property (p_speed)
        else $error("select timing field wrong");

    c_par: cover property (@(posedge clk) disable iff (!arst_n)
        ev_data_par ##1 par_r);
    c_clear: cover property (@(posedge clk) disable iff (!arst_n)
        par_r ##1 !par_r);
    c_intx: cover property (@(posedge clk) disable iff (!arst_n)
        intx_assert ##1 !intx_assert && int_r);
endmodule

// ### tb/pcs_host_model.sv
// ****************************************
// configuration host issuing dword 04h accesses
// ****************************************
module pcs_host_model (
    input wire logic clk,
    input wire logic [31:0] cfg_rdata,
    output logic cfg_sel,
    output logic cfg_wr,
    output logic [3:0] cfg_be,
    output logic [31:0] cfg_wdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        cfg_sel = 1'b0;
        cfg_wr = 1'b0;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0;
    end
    // host must set memory enable before touching link registers
    task automatic wr(input logic [3:0] be, input logic [31:0] d);
        @(posedge clk);
        #1;
        cfg_sel = 1'b1;
        cfg_wr = 1'b1;
        cfg_be = be;
        cfg_wdata = d;
        @(posedge clk);
        #1;
        cfg_sel = 1'b0;
        cfg_wr = 1'b0;
        cfg_be = 4'h0;
        // released data must not look like the last value
        cfg_wdata = ~d;
    endtask
    task automatic rd(output logic [31:0] d);
        @(posedge clk);
        #1;
        @(posedge clk);
        #1;
        d = cfg_rdata;
    endtask
endmodule

// ### tb/test_pcs_regs.sv
module test_pcs_regs;
    timeunit 1ns;
    timeprecision 100ps;
    import pcs_pkg::*;
    logic clk, arst_n, sel, wr, irq;
    logic [3:0] be;
    logic [31:0] wd, rdat, r;
    logic [6:0] ev;
    logic [9:0] en;
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;
    localparam int BIT_OF[7] = '{15, 15, 8, 13, 12, 11, 14};
    pcs_host_model host (.clk(clk), .cfg_rdata(rdat), .cfg_sel(sel),
        .cfg_wr(wr), .cfg_be(be), .cfg_wdata(wd));
    pcs_regs dut (.clk(clk), .arst_n(arst_n), .cfg_sel(sel), .cfg_wr(wr),
        .cfg_be(be), .cfg_wdata(wd), .cfg_rdata(rdat),
        .ev_addr_par(ev[0]), .ev_data_par(ev[1]),
        .ev_data_par_master(ev[2]), .ev_master_abort(ev[3]),
        .ev_target_abort_rx(ev[4]), .ev_target_abort_tx(ev[5]),
        .ev_serr_asserted(ev[6]), .irq_pending(irq),
        .memory_space_en(en[9]), .initiator_en(en[8]),
        .write_invalidate_en(en[7]), .parity_report_en(en[6]),
        .system_error_drive_en(en[5]), .io_space_en(en[4]),
        .palette_snoop_en(en[3]), .back_to_back_en(en[2]),
        .special_cycle_en(en[1]), .intx_assert(en[0]));
    // ****************************************
    // clock, timeout and reporting
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic report_and_stop();
        if (n_mismatch == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        arst_n = 1'b0;
        ev = 7'h0;
        irq = 1'b0;
        repeat (16) @(posedge clk);
        #1;
        arst_n = 1'b1;
        host.rd(r);
        chk(r, 32'h0210_0000);
        chk({22'h0, en}, 32'h0);
        host.wr(4'h3, 32'hffff_ffff);
        host.rd(r);
        chk(r, 32'h0210_0556);
        chk({22'h0, en}, 32'h3e0);
        for (int k = 0; k < 7; k++) begin
            @(posedge clk);
            #1;
            ev[k] = 1'b1;
            @(posedge clk);
            #1;
            ev = 7'h0;
            repeat (4) @(posedge clk);
            host.rd(r);
            // the one flag raised must be set, every other bit untouched
            r = r ^ (32'h1 << (16 + BIT_OF[k]));
            chk(r, 32'h0210_0556);
            host.wr(4'hc, 32'hffff_0000);
            host.rd(r);
            chk(r, 32'h0210_0556);
        end
        irq = 1'b1;
        host.wr(4'h3, 32'h0000_0156);
        host.rd(r);
        chk(r, 32'h0218_0156);
        chk({31'h0, en[0]}, 32'h1);
        host.wr(4'h3, 32'h0000_0556);
        host.rd(r);
        chk(r, 32'h0218_0556);
        chk({31'h0, en[0]}, 32'h0);
        irq = 1'b0;
        host.wr(4'h3, 32'h0);
        host.rd(r);
        chk(r, 32'h0210_0000);
        chk({22'h0, en}, 32'h0);
        // enable-gated events stay silent while the command is clear
        ev = 7'h44;
        @(posedge clk);
        #1;
        ev = 7'h0;
        host.rd(r);
        chk(r, 32'h0210_0000);
        // an event in the cycle of its own clear still sets the flag
        fork
            host.wr(4'hc, 32'h2000_0000);
            begin
                @(posedge clk);
                #1;
                ev[3] = 1'b1;
                @(posedge clk);
                #1;
                ev = 7'h0;
            end
        join
        host.rd(r);
        chk(r, 32'h2210_0000);
        host.wr(4'hc, 32'h2000_0000);
        host.rd(r);
        chk(r, 32'h0210_0000);
        // a reset in mid-run returns every field to its default
        host.wr(4'h3, 32'h0000_0556);
        arst_n = 1'b0;
        #1;
        chk(rdat, 32'h0);
        chk({22'h0, en}, 32'h0);
        repeat (16) @(posedge clk);
        #1;
        arst_n = 1'b1;
        host.rd(r);
        chk(r, 32'h0210_0000);
        chk({22'h0, en}, 32'h0);
        report_and_stop();
    end
endmodule
